// ==== rtl/bms_pkg.sv ====
// Purpose: shared constants and types of the beacon mode sequencer
// Assumes: 125 MHz system clock, 32-bit AXI4-Lite register bus
// Notes: timeouts count in 100 ms ticks
package bms_pkg;
	// clock and tick timing
	localparam int CLK_HZ = 125_000_000;
	localparam int TICK_HZ = 10;
	localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
	localparam int TMO_DEFAULT_S = 60;
	localparam logic [15:0] TMO_RST = 16'(TMO_DEFAULT_S * TICK_HZ);
	// reboot delay in ticks; plain default
	localparam logic [15:0] REBOOT_RST = 16'h0064;

	// register byte offsets
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CFG_TMO = 8'h04;
	localparam logic [7:0] OFS_ACT_TMO = 8'h08;
	localparam logic [7:0] OFS_REBOOT = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

	// control register fields
	localparam int CTRL_W = 8;
	localparam int CTRL_STARTUP_WH = 0;
	localparam int CTRL_SENS_OFF = 1;
	localparam int CTRL_TMO_BEACON = 2;
	localparam int CTRL_ONOFF_FLIP = 3;
	localparam int CTRL_CFG_FLIP = 4;
	localparam int CTRL_ACT_LSB = 5;
	localparam logic [7:0] CTRL_RST = 8'h10;

	// activity event sources
	localparam logic [2:0] ACT_OFF = 3'h0;
	localparam logic [2:0] ACT_MOVE = 3'h1;
	localparam logic [2:0] ACT_TAP = 3'h2;
	localparam logic [2:0] ACT_DTAP = 3'h3;
	localparam logic [2:0] ACT_FALL = 3'h4;
	localparam logic [2:0] ACT_FLIP = 3'h5;

	// status register fields
	localparam int ST_MODE_LSB = 0;
	localparam int ST_LOCK = 3;
	localparam int ST_FAIL = 4;
	localparam int ST_ACTIVE = 5;
	localparam int ST_CONN = 6;
	localparam int ST_ERR_LSB = 8;

	// interrupt bits
	localparam int IRQ_W = 4;
	localparam int IRQ_MODE = 0;
	localparam int IRQ_POSTFAIL = 1;
	localparam int IRQ_LOCK = 2;
	localparam int IRQ_REBOOT = 3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// gray codes in listing order; selftest -> warehouse changes two bits
	typedef enum logic [2:0] {
		BMS_SELFTEST = 3'h0,
		BMS_BEACON = 3'h1,
		BMS_WAREHOUSE = 3'h3,
		BMS_CONFIG = 3'h2,
		BMS_CONNECTED = 3'h6,
		BMS_FAILCFG = 3'h4,
		BMS_REBOOT = 3'h5
	} bms_state_t;
endpackage

// ==== rtl/bms_tick_div.sv ====
// Purpose: one-cycle tick enable every CYCLES clocks
// Assumes: single system clock
// Notes: drives all slow timeouts of the sequencer
`timescale 1ns/1ps
module bms_tick_div import bms_pkg::*; #(
	parameter int CYCLES = TICK_CYCLES
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_sys_rst,
	// tick
	output logic o_tick
);
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} bms_div_t;

	bms_div_t r, n;

	if (CYCLES < 2) begin : g_chk
		$error("tick divider needs at least two cycles");
	end

	always_comb begin
		n = r;
		n.tick = 1'b0;
		if (r.cnt == 32'(CYCLES - 1)) begin
			n.cnt = 32'h0;
			n.tick = 1'b1;
		end else begin
			n.cnt = r.cnt + 32'h1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign o_tick = r.tick;
endmodule

// ==== rtl/bms_mode_seq.sv ====
// Purpose: operating-mode sequencer of a motion-sensing proximity beacon
// Assumes: event inputs are one-cycle pulses synchronous to i_clock
// Notes: registers reached over AXI4-Lite, one outstanding access per channel
// Operation
// - after every reset a self-test of sensor, both crystals and stored configuration runs before any mode.
// - a passed self-test leads straight into the configured startup mode.
// - a failed self-test switches the sensor off and holds configuration mode until the reboot delay ends, then resets.
// - in that failure mode a client may connect, configuration may be written and the error code is readable.
// - startup mode follows self-test and configuration timeout, and is warehouse or beaconing, beaconing by default.
// - configuration and activity timeouts run from 0.1 to 6553.5 s and default to 60 s.
// - warehouse mode is the lowest-power state and is left on configuration, on/off or lock events.
// - in warehouse mode the sensor samples only when a configuration or on/off source is flip, else it is off; the code keeps o_sens_en high.
// - a configuration bit disables the sensor altogether, which is enabled by default.
// - lock-sensitive transitions stay disabled forever once a lock event has happened; the code records lock events only in warehouse and beaconing mode.
// - the configuration timeout exit can be set to lead to beaconing instead of the startup mode.
// - self-test dependent transitions are blocked while the last self-test has failed.
// - the modes are a fixed set of states, altered only through configuration values.
// - entering configuration mode starts its timer, and expiry without a connection returns to startup mode.
// - a connection holds until the remote side drops it, then startup mode follows unless a reset was asked for.
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module bms_mode_seq import bms_pkg::*; #(
	parameter int TICK_CYC = TICK_CYCLES
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_sys_rst,
	// self-test results
	input wire logic i_selftest_done,
	input wire logic i_sens_ok,
	input wire logic i_hfxo_ok,
	input wire logic i_lfxo_ok,
	input wire logic i_cfg_valid,
	// motion sensor events
	input wire logic i_flip,
	input wire logic i_move,
	input wire logic i_tap,
	input wire logic i_dtap,
	input wire logic i_freefall,
	input wire logic i_lock,
	// radio link
	input wire logic i_connect,
	input wire logic i_disconnect,
	input wire logic i_reset_req,
	// mode outputs
	output bms_state_t o_mode,
	output logic o_selftest_run,
	output logic o_sens_en,
	output logic o_sens_sample,
	output logic o_active,
	output logic o_dev_reset,
	output logic o_irq,
	// axi4-lite write
	input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready
);
	typedef struct packed {
		bms_state_t state;
		logic [CTRL_W-1:0] ctrl;
		logic [15:0] cfg_tmo;
		logic [15:0] act_tmo;
		logic [15:0] reboot;
		logic [15:0] tmr;
		logic [15:0] act_cnt;
		logic locked;
		logic power_on_self_test_fail;
		logic [3:0] err;
		logic conn;
		logic rst_req;
		logic st_run;
		logic sens_en;
		logic sens_sample;
		logic active;
		logic dev_rst;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic irq;
		logic aw_hold;
		logic [ADDR_W-1:0] awaddr;
		logic w_hold;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} bms_reg_t;

	bms_reg_t r, n;
	logic tick;

	if (TICK_CYC < 2) begin : g_chk
		$error("tick period must be at least two cycles");
	end

	bms_tick_div #(
		.CYCLES(TICK_CYC)
	) u_tick (
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.o_tick(tick)
	);

	function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				res[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// a programmed zero is raised to one tick, the shortest legal value
	function automatic logic [15:0] clamp_tmo(input logic [31:0] v);
		return (v[15:0] == 16'h0) ? 16'h1 : v[15:0];
	endfunction

	logic power_on_self_test_ok;
	logic flip_ok;
	logic cfg_evt;
	logic onoff_evt;
	logic act_evt;
	logic tmr_exp;
	logic do_wr;
	bms_state_t startup;
	logic [IRQ_W-1:0] irq_ev;
	logic [31:0] wv;

	always_comb begin
		n = r;
		irq_ev = '0;
		wv = 32'h0;
		power_on_self_test_ok = i_sens_ok & i_hfxo_ok & i_lfxo_ok & i_cfg_valid;
		startup = r.ctrl[CTRL_STARTUP_WH] ? BMS_WAREHOUSE : BMS_BEACON;
		flip_ok = i_flip & ~r.ctrl[CTRL_SENS_OFF];
		// flip events are gated by the last self-test result
		cfg_evt = flip_ok & r.ctrl[CTRL_CFG_FLIP] & ~r.power_on_self_test_fail;
		onoff_evt = flip_ok & r.ctrl[CTRL_ONOFF_FLIP] & ~r.power_on_self_test_fail;
		unique case (r.ctrl[CTRL_ACT_LSB +: 3])
			ACT_MOVE: act_evt = i_move;
			ACT_TAP: act_evt = i_tap;
			ACT_DTAP: act_evt = i_dtap;
			ACT_FALL: act_evt = i_freefall;
			ACT_FLIP: act_evt = i_flip;
			default: act_evt = 1'b0;
		endcase
		act_evt = act_evt & ~r.ctrl[CTRL_SENS_OFF];
		tmr_exp = tick & (r.tmr <= 16'h1);
		if (tick && r.tmr != 16'h0) begin
			n.tmr = r.tmr - 16'h1;
		end

		// fixed set of modes; behaviour varies only through ctrl and timeout values
		unique case (r.state)
			BMS_SELFTEST: begin
				if (i_selftest_done) begin
					n.power_on_self_test_fail = ~power_on_self_test_ok;
					n.err = {~i_cfg_valid, ~i_lfxo_ok, ~i_hfxo_ok, ~i_sens_ok};
					n.state = power_on_self_test_ok ? startup : BMS_FAILCFG;
				end
			end
			BMS_WAREHOUSE: begin
				if (i_lock) begin
					n.locked = 1'b1;
					n.state = BMS_BEACON;
				end else if (cfg_evt && !r.locked) begin
					n.state = BMS_CONFIG;
				end else if (onoff_evt && !r.locked) begin
					n.state = BMS_BEACON;
				end
			end
			BMS_BEACON: begin
				if (i_lock) begin
					n.locked = 1'b1;
				end else if (cfg_evt && !r.locked) begin
					n.state = BMS_CONFIG;
				end else if (onoff_evt && !r.locked) begin
					n.state = BMS_WAREHOUSE;
				end
			end
			BMS_CONFIG: begin
				if (i_connect) begin
					n.state = BMS_CONNECTED;
					n.conn = 1'b1;
					n.rst_req = 1'b0;
				end else if (tmr_exp && !r.power_on_self_test_fail) begin
					n.state = r.ctrl[CTRL_TMO_BEACON] ? BMS_BEACON : startup;
				end
			end
			BMS_CONNECTED: begin
				if (i_reset_req) begin
					n.rst_req = 1'b1;
				end
				if (i_disconnect) begin
					n.conn = 1'b0;
					n.state = (r.rst_req | i_reset_req) ? BMS_REBOOT : startup;
				end
			end
			BMS_FAILCFG: begin
				// client may connect and rewrite config while the reboot delay runs
				if (i_connect) begin
					n.conn = 1'b1;
				end else if (i_disconnect) begin
					n.conn = 1'b0;
				end
				if (tmr_exp) begin
					n.state = BMS_REBOOT;
				end
			end
			BMS_REBOOT: begin
				n.conn = 1'b0;
				n.state = BMS_SELFTEST;
			end
			default: n.state = BMS_SELFTEST;
		endcase

		// entry loads of the mode timers
		if (n.state != r.state) begin
			irq_ev[IRQ_MODE] = 1'b1;
			if (n.state == BMS_CONFIG) begin
				n.tmr = r.cfg_tmo;
			end
			if (n.state == BMS_FAILCFG) begin
				n.tmr = r.reboot;
				irq_ev[IRQ_POSTFAIL] = 1'b1;
			end
			if (n.state == BMS_BEACON) begin
				n.act_cnt = r.act_tmo;
			end
			if (n.state == BMS_REBOOT) begin
				irq_ev[IRQ_REBOOT] = 1'b1;
			end
		end else if (r.state == BMS_BEACON) begin
			if (act_evt) begin
				n.act_cnt = r.act_tmo;
			end else if (tick && r.act_cnt != 16'h0) begin
				n.act_cnt = r.act_cnt - 16'h1;
			end
		end
		irq_ev[IRQ_LOCK] = n.locked & ~r.locked;

		// axi write: address and data taken in either order
		if (i_s_axi_awvalid && r.awready) begin
			n.aw_hold = 1'b1;
			n.awaddr = i_s_axi_awaddr;
		end
		if (i_s_axi_wvalid && r.wready) begin
			n.w_hold = 1'b1;
			n.wdata = i_s_axi_wdata;
			n.wstrb = i_s_axi_wstrb;
		end
		if (r.bvalid && i_s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		do_wr = r.aw_hold & r.w_hold & ~r.bvalid;
		n.irq_stat = r.irq_stat;
		if (do_wr) begin
			n.aw_hold = 1'b0;
			n.w_hold = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			unique case (r.awaddr)
				OFS_CTRL: begin
					wv = merge_strb({24'h0, r.ctrl}, r.wdata, r.wstrb);
					n.ctrl = wv[CTRL_W-1:0];
				end
				OFS_CFG_TMO: begin
					wv = merge_strb({16'h0, r.cfg_tmo}, r.wdata, r.wstrb);
					n.cfg_tmo = clamp_tmo(wv);
				end
				OFS_ACT_TMO: begin
					wv = merge_strb({16'h0, r.act_tmo}, r.wdata, r.wstrb);
					n.act_tmo = clamp_tmo(wv);
				end
				OFS_REBOOT: begin
					wv = merge_strb({16'h0, r.reboot}, r.wdata, r.wstrb);
					n.reboot = clamp_tmo(wv);
				end
				OFS_STATUS: begin
				end
				OFS_IRQ_STAT: begin
					wv = merge_strb(32'h0, r.wdata, r.wstrb);
					n.irq_stat = r.irq_stat & ~wv[IRQ_W-1:0];
				end
				OFS_IRQ_MASK: begin
					wv = merge_strb({28'h0, r.irq_mask}, r.wdata, r.wstrb);
					n.irq_mask = wv[IRQ_W-1:0];
				end
				default: n.bresp = RESP_SLVERR;
			endcase
		end
		// a new event wins over a clear in the same cycle
		n.irq_stat = n.irq_stat | irq_ev;

		// axi read
		if (r.rvalid && i_s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (i_s_axi_arvalid && r.arready) begin
			n.rvalid = 1'b1;
			n.rresp = RESP_OKAY;
			n.rdata = 32'h0;
			unique case (i_s_axi_araddr)
				OFS_CTRL: n.rdata = {24'h0, r.ctrl};
				OFS_CFG_TMO: n.rdata = {16'h0, r.cfg_tmo};
				OFS_ACT_TMO: n.rdata = {16'h0, r.act_tmo};
				OFS_REBOOT: n.rdata = {16'h0, r.reboot};
				OFS_STATUS: begin
					n.rdata[ST_MODE_LSB +: 3] = r.state;
					n.rdata[ST_LOCK] = r.locked;
					n.rdata[ST_FAIL] = r.power_on_self_test_fail;
					n.rdata[ST_ACTIVE] = r.active;
					n.rdata[ST_CONN] = r.conn;
					n.rdata[ST_ERR_LSB +: 4] = r.err;
				end
				OFS_IRQ_STAT: n.rdata = {28'h0, r.irq_stat};
				OFS_IRQ_MASK: n.rdata = {28'h0, r.irq_mask};
				default: n.rresp = RESP_SLVERR;
			endcase
		end
		n.arready = ~n.rvalid;
		n.awready = ~n.aw_hold & ~n.bvalid;
		n.wready = ~n.w_hold & ~n.bvalid;

		// registered outputs derived from the next state
		n.st_run = (n.state == BMS_SELFTEST);
		n.sens_en = ~n.ctrl[CTRL_SENS_OFF] & (n.state != BMS_FAILCFG) & (n.state != BMS_SELFTEST);
		if (n.state == BMS_WAREHOUSE) begin
			n.sens_sample = n.sens_en & (n.ctrl[CTRL_CFG_FLIP] | n.ctrl[CTRL_ONOFF_FLIP]);
		end else begin
			n.sens_sample = n.sens_en;
		end
		n.active = (n.state == BMS_BEACON) & ((n.ctrl[CTRL_ACT_LSB +: 3] == ACT_OFF) | (n.act_cnt != 16'h0));
		n.dev_rst = (n.state == BMS_REBOOT);
		n.irq = |(n.irq_stat & n.irq_mask);
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			r <= '0;
			r.state <= BMS_SELFTEST;
			r.st_run <= 1'b1;
			r.ctrl <= CTRL_RST;
			r.cfg_tmo <= TMO_RST;
			r.act_tmo <= TMO_RST;
			r.reboot <= REBOOT_RST;
		end else begin
			r <= n;
		end
	end

	assign o_mode = r.state;
	assign o_selftest_run = r.st_run;
	assign o_sens_en = r.sens_en;
	assign o_sens_sample = r.sens_sample;
	assign o_active = r.active;
	assign o_dev_reset = r.dev_rst;
	assign o_irq = r.irq;
	assign o_s_axi_awready = r.awready;
	assign o_s_axi_wready = r.wready;
	assign o_s_axi_bresp = r.bresp;
	assign o_s_axi_bvalid = r.bvalid;
	assign o_s_axi_arready = r.arready;
	assign o_s_axi_rdata = r.rdata;
	assign o_s_axi_rresp = r.rresp;
	assign o_s_axi_rvalid = r.rvalid;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);

	AST_POWER_ON_SELF_TEST_FIRST: assert property ($fell(i_sys_rst) |-> o_mode == BMS_SELFTEST && o_selftest_run)
		else $error("self-test not first after reset");
	AST_PASS_START: assert property (o_mode == BMS_SELFTEST && i_selftest_done && power_on_self_test_ok
		|=> o_mode == ($past(r.ctrl[CTRL_STARTUP_WH]) ? BMS_WAREHOUSE : BMS_BEACON))
		else $error("passed self-test did not enter startup mode");
	AST_FAIL_CFG: assert property (o_mode == BMS_SELFTEST && i_selftest_done && !power_on_self_test_ok
		|=> o_mode == BMS_FAILCFG && !o_sens_en && r.tmr == $past(r.reboot))
		else $error("failed self-test did not enter failure config mode");
	AST_FAIL_ERR: assert property (o_mode == BMS_SELFTEST && i_selftest_done
		|=> r.power_on_self_test_fail == !$past(power_on_self_test_ok) && r.err == ~$past({i_cfg_valid, i_lfxo_ok, i_hfxo_ok, i_sens_ok}))
		else $error("self-test error code not captured");
	AST_TMO_RANGE: assert property (r.cfg_tmo != 16'h0 && r.act_tmo != 16'h0)
		else $error("timeout programmed to zero");
	AST_WH_SAMPLE: assert property (o_mode == BMS_WAREHOUSE
		|-> o_sens_sample == (o_sens_en && (r.ctrl[CTRL_CFG_FLIP] || r.ctrl[CTRL_ONOFF_FLIP])))
		else $error("warehouse sensor sampling wrong");
	AST_SENS_OFF: assert property (r.ctrl[CTRL_SENS_OFF] |-> !o_sens_en && !o_sens_sample)
		else $error("sensor enabled while disabled by config");
	AST_LOCK_KEEP: assert property (r.locked && o_mode == BMS_BEACON
		|=> o_mode != BMS_CONFIG && o_mode != BMS_WAREHOUSE)
		else $error("lock-sensitive transition taken after lock");
	AST_TMO_BEACON: assert property (o_mode == BMS_CONFIG && tmr_exp && !i_connect && !r.power_on_self_test_fail
		&& r.ctrl[CTRL_TMO_BEACON] |=> o_mode == BMS_BEACON)
		else $error("config timeout did not lead to beaconing");
	AST_CFG_LOAD: assert property (o_mode == BMS_CONFIG && $past(o_mode) != BMS_CONFIG
		|-> r.tmr == $past(r.cfg_tmo))
		else $error("config timer not loaded on entry");
	AST_CONN_HOLD: assert property (o_mode == BMS_CONNECTED && !i_disconnect |=> o_mode == BMS_CONNECTED)
		else $error("connection left without disconnect");
	AST_TMR_DEC: assert property (o_mode == BMS_CONFIG && tick && r.tmr > 16'h1 && !i_connect
		|=> r.tmr == $past(r.tmr) - 16'h1)
		else $error("mode timer did not count down on tick");
	AST_REBOOT: assert property (o_mode == BMS_FAILCFG && tmr_exp
		|=> o_dev_reset ##1 o_mode == BMS_SELFTEST && !o_dev_reset)
		else $error("reboot delay expiry did not reset");
endmodule

// ==== bench/bms_partner.sv ====
// Purpose: far-side model: motion sensor events, self-test results, radio link client
// Assumes: driven from the bench through its tasks, changes only after a rising edge
// Notes: event outputs are one-cycle pulses, never held longer
`timescale 1ns/1ps
module bms_partner (
	// clock
	input wire logic i_clock,
	// self-test results
	output logic o_selftest_done,
	output logic o_sens_ok,
	output logic o_hfxo_ok,
	output logic o_lfxo_ok,
	output logic o_cfg_valid,
	// sensor and link events
	output logic o_flip,
	output logic o_move,
	output logic o_tap,
	output logic o_dtap,
	output logic o_freefall,
	output logic o_lock,
	output logic o_connect,
	output logic o_disconnect,
	output logic o_reset_req
);
	logic [8:0] ev_r;
	assign {o_reset_req, o_disconnect, o_connect, o_lock, o_freefall, o_dtap, o_tap, o_move, o_flip} = ev_r;
	initial begin
		ev_r = '0;
		o_selftest_done = 1'b0;
		{o_cfg_valid, o_lfxo_ok, o_hfxo_ok, o_sens_ok} = 4'hf;
	end
	// one pulse per call; the remote side ends the link through the disconnect bit
	task automatic pulse(input logic [8:0] m);
		@(posedge i_clock);
		ev_r <= m;
		@(posedge i_clock);
		ev_r <= '0;
	endtask
	// results stay as levels after the strobe, as a real checker would leave them
	task automatic selftest(input logic [3:0] ok);
		@(posedge i_clock);
		{o_cfg_valid, o_lfxo_ok, o_hfxo_ok, o_sens_ok} <= ok;
		o_selftest_done <= 1'b1;
		@(posedge i_clock);
		o_selftest_done <= 1'b0;
	endtask
endmodule

// ==== bench/tb_beacon_mode_sequencer.sv ====
// Purpose: self-checking bench of the mode sequencer
// Assumes: tick shortened to TC cycles so timeouts count in a few cycles
// Notes: mode outputs are sampled at the falling edge, bus responses at the rising edge; inputs change after the rising edge
`timescale 1ns/1ps
module tb_beacon_mode_sequencer;
	import bms_pkg::*;
	localparam int TC = 4;
	localparam logic [8:0] EV_FLIP = 9'h001;
	localparam logic [8:0] EV_MOVE = 9'h002;
	localparam logic [8:0] EV_TAP = 9'h004;
	localparam logic [8:0] EV_LOCK = 9'h020;
	localparam logic [8:0] EV_CONN = 9'h040;
	localparam logic [8:0] EV_DISC = 9'h080;
	localparam logic [8:0] EV_RREQ = 9'h100;
	logic i_clock = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_selftest_done, i_sens_ok, i_hfxo_ok, i_lfxo_ok, i_cfg_valid, i_flip, i_move, i_tap, i_dtap;
	logic i_freefall, i_lock, i_connect, i_disconnect, i_reset_req;
	bms_state_t o_mode;
	logic o_selftest_run, o_sens_en, o_sens_sample, o_active, o_dev_reset, o_irq;
	logic [7:0] i_s_axi_awaddr = '0;
	logic [7:0] i_s_axi_araddr = '0;
	logic [31:0] i_s_axi_wdata = '0;
	logic [3:0] i_s_axi_wstrb = '0;
	logic i_s_axi_awvalid = 1'b0;
	logic i_s_axi_wvalid = 1'b0;
	logic i_s_axi_bready = 1'b0;
	logic i_s_axi_arvalid = 1'b0;
	logic i_s_axi_rready = 1'b0;
	logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
	logic [1:0] o_s_axi_bresp, o_s_axi_rresp, rr, br;
	logic [31:0] o_s_axi_rdata, rd;
	int miscompares = 0;
	int checks = 0;
	int cycles = 0;

	always #4 i_clock = ~i_clock;

	bms_partner bms_partner_inst (.i_clock(i_clock), .o_selftest_done(i_selftest_done), .o_sens_ok(i_sens_ok),
		.o_hfxo_ok(i_hfxo_ok), .o_lfxo_ok(i_lfxo_ok), .o_cfg_valid(i_cfg_valid), .o_flip(i_flip), .o_move(i_move),
		.o_tap(i_tap), .o_dtap(i_dtap), .o_freefall(i_freefall), .o_lock(i_lock), .o_connect(i_connect),
		.o_disconnect(i_disconnect), .o_reset_req(i_reset_req));

	bms_mode_seq #(.TICK_CYC(TC)) bms_mode_seq_inst (.i_clock, .i_sys_rst, .i_selftest_done, .i_sens_ok,
		.i_hfxo_ok, .i_lfxo_ok, .i_cfg_valid, .i_flip, .i_move, .i_tap, .i_dtap, .i_freefall, .i_lock,
		.i_connect, .i_disconnect, .i_reset_req, .o_mode, .o_selftest_run, .o_sens_en, .o_sens_sample,
		.o_active, .o_dev_reset, .o_irq, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata,
		.i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready,
		.i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid,
		.i_s_axi_rready);

	task automatic print_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// whole run needs well under a thousand cycles; this ceiling only catches a hang
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			print_verdict();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge i_clock);
		i_s_axi_awaddr <= a;
		i_s_axi_awvalid <= 1'b1;
		i_s_axi_wdata <= d;
		i_s_axi_wstrb <= 4'hf;
		i_s_axi_wvalid <= 1'b1;
		i_s_axi_bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge i_clock);
			if (!aw_done && o_s_axi_awready) begin
				aw_done = 1'b1;
				i_s_axi_awvalid <= 1'b0;
			end
			if (!w_done && o_s_axi_wready) begin
				w_done = 1'b1;
				i_s_axi_wvalid <= 1'b0;
			end
		end
		while (o_s_axi_bvalid !== 1'b1) @(posedge i_clock);
		br = o_s_axi_bresp;
		i_s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge i_clock);
		i_s_axi_araddr <= a;
		i_s_axi_arvalid <= 1'b1;
		i_s_axi_rready <= 1'b1;
		do @(posedge i_clock); while (o_s_axi_arready !== 1'b1);
		i_s_axi_arvalid <= 1'b0;
		while (o_s_axi_rvalid !== 1'b1) @(posedge i_clock);
		d = o_s_axi_rdata;
		r = o_s_axi_rresp;
		i_s_axi_rready <= 1'b0;
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		axi_rd(a, rd, rr);
		chk(nm, rd & m, e);
		chk({nm, " resp"}, 32'(rr), 32'(RESP_OKAY));
	endtask

	task automatic wmode(input bms_state_t m, input int lim);
		for (int n = 0; n < lim; n++) begin
			@(negedge i_clock);
			if (o_mode === m) break;
		end
		chk("mode", 32'(o_mode), 32'(m));
	endtask

	task automatic hold(input bms_state_t m, input int n);
		repeat (n) @(negedge i_clock);
		chk("mode held", 32'(o_mode), 32'(m));
	endtask

	task automatic do_reset;
		@(posedge i_clock);
		i_sys_rst <= 1'b1;
		repeat (10) @(posedge i_clock);
		i_sys_rst <= 1'b0;
	endtask

	task automatic t_defaults;
		logic [7:0] ofs [6] = '{OFS_CTRL, OFS_CFG_TMO, OFS_ACT_TMO, OFS_REBOOT, OFS_IRQ_STAT, OFS_IRQ_MASK};
		logic [31:0] dv [6] = '{32'h10, 32'h258, 32'h258, 32'h64, 32'h0, 32'h0};
		hold(BMS_SELFTEST, 5);
		chk("selftest_run", 32'(o_selftest_run), 32'h1);
		chk("sens_en", 32'(o_sens_en), 32'h0);
		for (int i = 0; i < 6; i++) rd_chk("reset value", ofs[i], 32'hffffffff, dv[i]);
		axi_wr(OFS_CFG_TMO, 32'h0);
		chk("write resp", 32'(br), 32'(RESP_OKAY));
		rd_chk("timeout floor", OFS_CFG_TMO, 32'hffffffff, 32'h1);
		axi_wr(OFS_CFG_TMO, 32'hffff);
		rd_chk("timeout ceiling", OFS_CFG_TMO, 32'hffffffff, 32'hffff);
		axi_rd(8'h1c, rd, rr);
		chk("unmapped data", rd, 32'h0);
		chk("unmapped resp", 32'(rr), 32'(RESP_SLVERR));
		axi_wr(8'h1c, 32'hffffffff);
		chk("unmapped write resp", 32'(br), 32'(RESP_SLVERR));
	endtask

	task automatic t_warehouse;
		axi_wr(OFS_CTRL, 32'h11);
		axi_wr(OFS_CFG_TMO, 32'h3);
		bms_partner_inst.selftest(4'hf);
		wmode(BMS_WAREHOUSE, 4);
		chk("sample", 32'(o_sens_sample), 32'h1);
		bms_partner_inst.pulse(EV_FLIP);
		wmode(BMS_CONFIG, 3);
		hold(BMS_CONFIG, 2 * TC - 1);
		wmode(BMS_WAREHOUSE, TC + 3);
		axi_wr(OFS_CTRL, 32'h01);
		repeat (2) @(negedge i_clock);
		chk("sample", 32'(o_sens_sample), 32'h0);
		bms_partner_inst.pulse(EV_FLIP);
		hold(BMS_WAREHOUSE, 3);
		axi_wr(OFS_CTRL, 32'h09);
		bms_partner_inst.pulse(EV_FLIP);
		wmode(BMS_BEACON, 3);
		axi_wr(OFS_CTRL, 32'h15);
		bms_partner_inst.pulse(EV_FLIP);
		wmode(BMS_CONFIG, 3);
		wmode(BMS_BEACON, 3 * TC + 3);
		axi_wr(OFS_CTRL, 32'h12);
		repeat (2) @(negedge i_clock);
		chk("sens_en", 32'(o_sens_en), 32'h0);
		bms_partner_inst.pulse(EV_FLIP);
		hold(BMS_BEACON, 3);
	endtask

	task automatic t_connect;
		axi_wr(OFS_CTRL, 32'h10);
		bms_partner_inst.pulse(EV_FLIP);
		wmode(BMS_CONFIG, 3);
		bms_partner_inst.pulse(EV_CONN);
		wmode(BMS_CONNECTED, 3);
		hold(BMS_CONNECTED, 5 * TC);
		bms_partner_inst.pulse(EV_DISC);
		wmode(BMS_BEACON, 3);
		bms_partner_inst.pulse(EV_FLIP);
		wmode(BMS_CONFIG, 3);
		bms_partner_inst.pulse(EV_CONN);
		wmode(BMS_CONNECTED, 3);
		bms_partner_inst.pulse(EV_RREQ);
		bms_partner_inst.pulse(EV_DISC);
		wmode(BMS_REBOOT, 3);
		chk("dev_reset", 32'(o_dev_reset), 32'h1);
		wmode(BMS_SELFTEST, 1);
	endtask

	task automatic t_lock;
		axi_wr(OFS_IRQ_MASK, 32'h4);
		axi_wr(OFS_CTRL, 32'h11);
		bms_partner_inst.selftest(4'hf);
		wmode(BMS_WAREHOUSE, 4);
		chk("irq masked", 32'(o_irq), 32'h0);
		bms_partner_inst.pulse(EV_LOCK);
		wmode(BMS_BEACON, 3);
		@(negedge i_clock);
		chk("irq", 32'(o_irq), 32'h1);
		rd_chk("locked", OFS_STATUS, 32'h8, 32'h8);
		bms_partner_inst.pulse(EV_FLIP);
		hold(BMS_BEACON, 3);
		axi_wr(OFS_IRQ_STAT, 32'h4);
		repeat (2) @(negedge i_clock);
		chk("irq cleared", 32'(o_irq), 32'h0);
		rd_chk("irq stat", OFS_IRQ_STAT, 32'h4, 32'h0);
	endtask

	task automatic t_fail;
		do_reset();
		axi_wr(OFS_REBOOT, 32'h28);
		bms_partner_inst.selftest(4'he);
		wmode(BMS_FAILCFG, 4);
		chk("sens_en", 32'(o_sens_en), 32'h0);
		rd_chk("fail status", OFS_STATUS, 32'hf17, 32'h114);
		bms_partner_inst.pulse(EV_FLIP);
		hold(BMS_FAILCFG, 3);
		bms_partner_inst.pulse(EV_CONN);
		rd_chk("conn", OFS_STATUS, 32'h47, 32'h44);
		axi_wr(OFS_CFG_TMO, 32'h7);
		rd_chk("cfg load", OFS_CFG_TMO, 32'hffffffff, 32'h7);
		wmode(BMS_REBOOT, 40 * TC + 10);
		chk("dev_reset", 32'(o_dev_reset), 32'h1);
		wmode(BMS_SELFTEST, 1);
		// mode change, self-test failure and reboot events since the reset
		rd_chk("irq events", OFS_IRQ_STAT, 32'hf, 32'hb);
	endtask

	task automatic t_activity;
		do_reset();
		axi_wr(OFS_CTRL, 32'h30);
		axi_wr(OFS_ACT_TMO, 32'h2);
		bms_partner_inst.selftest(4'hf);
		wmode(BMS_BEACON, 4);
		@(negedge i_clock);
		chk("active", 32'(o_active), 32'h1);
		repeat (3 * TC) @(negedge i_clock);
		chk("inactive", 32'(o_active), 32'h0);
		bms_partner_inst.pulse(EV_MOVE);
		repeat (2) @(negedge i_clock);
		chk("active again", 32'(o_active), 32'h1);
		axi_wr(OFS_CTRL, 32'h50);
		repeat (3 * TC) @(negedge i_clock);
		bms_partner_inst.pulse(EV_MOVE);
		repeat (2) @(negedge i_clock);
		chk("move ignored", 32'(o_active), 32'h0);
		bms_partner_inst.pulse(EV_TAP);
		repeat (2) @(negedge i_clock);
		chk("tap active", 32'(o_active), 32'h1);
	endtask

	initial begin
		do_reset();
		t_defaults();
		t_warehouse();
		t_connect();
		t_lock();
		t_fail();
		t_activity();
		print_verdict();
	end
endmodule
